//--- rtl/elc_pkg.sv
// shared constants, register map and types of the embedded logic capture block
`default_nettype none
package elc_pkg;
	// ========================================
	// sizes
	localparam int ELC_PROBE_WIDTH = 128;
	localparam int ELC_INT_AW = 8;
	localparam int ELC_EXT_AW = 12;
	localparam int ELC_IDX_BITS = 9;
	localparam int ELC_MAX_PKT = 16;
	localparam int ELC_DBG_W = 32;
	localparam int ELC_EVT_W = 3;

	// ========================================
	// register byte offsets
	localparam logic [7:0] ELC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] ELC_ADDR_STATUS = 8'h04;
	localparam logic [7:0] ELC_ADDR_TRIGPOS = 8'h08;
	localparam logic [7:0] ELC_ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ELC_ADDR_IRQ_EN = 8'h10;
	localparam logic [7:0] ELC_ADDR_IRQ_CLR = 8'h14;
	localparam logic [7:0] ELC_ADDR_DEBUG = 8'h18;

	// ========================================
	// field positions
	localparam int ELC_CTRL_START = 3;
	localparam int ELC_CTRL_STOP = 4;
	localparam int ELC_EVT_TRIG = 0;
	localparam int ELC_EVT_DONE = 1;
	localparam int ELC_EVT_RDONE = 2;
	localparam int ELC_STAT_FILL_LSB = 16;
	localparam int ELC_TPOS_CFG_LSB = 16;

	// ========================================
	// reset values
	localparam logic [2:0] ELC_CTRL_RST = 3'h0;
	localparam logic [ELC_EVT_W-1:0] ELC_IRQ_RST = 3'h0;

	// ========================================
	// types
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} elc_reg_req_t;

	typedef struct packed {
		logic alarm_src;
		logic ext_store;
		logic continuous;
	} elc_ctrl_t;

	typedef enum logic [2:0] {ST_IDLE, ST_CAPTURE, ST_POST, ST_DONE, ST_LOAD, ST_WAIT, ST_FETCH, ST_SHIFT} elc_state_t;
endpackage
`default_nettype wire

//--- rtl/elc_fill_alarm.sv
// fill-level alarm from write and read pointers and the 32-bit debug word
`default_nettype none
module elc_fill_alarm import elc_pkg::*; #(
	parameter int IDX_BITS = ELC_IDX_BITS,
	parameter int MAX_PKT = ELC_MAX_PKT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [IDX_BITS:0] write_ptr,
	input wire logic [IDX_BITS:0] read_ptr,
	input wire logic inbound_store_strobe,
	input wire logic sorter_store_strobe,
	input wire logic merged_store_strobe,
	input wire logic [IDX_BITS-1:0] inbound_write_location,
	input wire logic [IDX_BITS-1:0] sorter_write_location,
	input wire logic [IDX_BITS-1:0] merged_write_location,
	output logic fill_alarm,
	output logic [ELC_DBG_W-1:0] debug_out
);
	localparam logic [IDX_BITS:0] THRESH = (IDX_BITS+1)'((2 ** IDX_BITS) - MAX_PKT);

	logic [IDX_BITS:0] used;
	logic [ELC_DBG_W-1:0] debug_reg;
	logic [ELC_DBG_W-1:0] debug_next;

	// ========================================
	// alarm keeps room for one more packet
	always_comb begin
		used = (IDX_BITS+1)'(write_ptr - read_ptr);
		fill_alarm = used > THRESH; // [RL10]
		debug_next = {fill_alarm, inbound_store_strobe, sorter_store_strobe, merged_store_strobe, 1'b0,
			inbound_write_location, sorter_write_location, merged_write_location}; // [RL11]
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			debug_reg <= 32'h0000_0000;
		end else begin
			debug_reg <= debug_next;
		end
	end

	assign debug_out = debug_reg;

	// ========================================
	// checks
	AST_ALARM_TO_DEBUG: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL11]
		fill_alarm |=> debug_out[ELC_DBG_W-1]) else $error("alarm missing from debug msb");
	AST_DEBUG_ZERO_BIT: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL11]
		##1 debug_out[3*IDX_BITS] == 1'b0) else $error("debug constant bit not zero");
	AST_ALARM_THRESH: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL10]
		(IDX_BITS+1)'(write_ptr - read_ptr) <= THRESH |-> !fill_alarm) else $error("alarm below threshold");
endmodule
`default_nettype wire

//--- rtl/elc_logging_core.sv
// embedded logic capture core: sampling, trigger window, sample store and serial readout
// How it works
// RL1: every probe bit is sampled on each core clock edge, and the readout clock is a separate slow input.
// RL2: a capture runs either until a trigger closes its window or continuously until software stops it.
// RL3: the trigger position may be any sample index from zero to the buffer depth minus one.
// RL4: on a trigger the buffer keeps position samples before it and depth minus position minus one after it.
// RL5: software selects the internal array or the external SRAM as the store, the latter being deeper.
// RL6: when the capture is complete the host clocks the stored samples out of the serial output, oldest first.
// RL7: the serial output advances and the configuration input is sampled on rising edges of the host readout clock.
// RL8: bits shifted in on the configuration input set the trigger position taken at the next capture start.
// RL9: an assertion of the selected trigger input marks the trigger sample.
// RL10: the fill alarm rises when write pointer minus read pointer exceeds the buffer size less the largest packet.
// RL11: the debug word carries the alarm, three store strobes, a zero bit and three write locations.
// RL12: a full window raises data ready and the store is not written again until readout ends.
//
// Local design decisions: strobed register access and the register offsets.
`default_nettype none
module elc_logging_core import elc_pkg::*; #(
	parameter int PROBE_WIDTH = ELC_PROBE_WIDTH,
	parameter int INT_AW = ELC_INT_AW,
	parameter int EXT_AW = ELC_EXT_AW,
	parameter int IDX_BITS = ELC_IDX_BITS,
	parameter int MAX_PKT = ELC_MAX_PKT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [PROBE_WIDTH-1:0] probe_inputs,
	input wire logic capture_trigger_in,
	input wire logic readout_shift_clock,
	input wire logic trigger_position_cfg,
	output logic capture_serial_out,
	output logic data_ready,
	input wire elc_reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic [EXT_AW-1:0] ext_sram_addr,
	output logic [PROBE_WIDTH-1:0] ext_sram_wdata,
	output logic ext_sram_we,
	input wire logic [PROBE_WIDTH-1:0] ext_sram_rdata,
	input wire logic [IDX_BITS:0] write_ptr,
	input wire logic [IDX_BITS:0] read_ptr,
	input wire logic inbound_store_strobe,
	input wire logic sorter_store_strobe,
	input wire logic merged_store_strobe,
	input wire logic [IDX_BITS-1:0] inbound_write_location,
	input wire logic [IDX_BITS-1:0] sorter_write_location,
	input wire logic [IDX_BITS-1:0] merged_write_location,
	output logic [ELC_DBG_W-1:0] debug_out
);
	localparam int CW = EXT_AW + 1;
	localparam int BW = $clog2(PROBE_WIDTH);
	localparam logic [CW-1:0] DEPTH_INT = CW'(2 ** INT_AW);
	localparam logic [CW-1:0] DEPTH_EXT = CW'(2 ** EXT_AW);

	logic fill_alarm;
	logic [PROBE_WIDTH-1:0] int_mem [2 ** INT_AW];
	logic [PROBE_WIDTH-1:0] int_rdata_reg;

	// ========================================
	// alarm and debug word
	elc_fill_alarm #(.IDX_BITS(IDX_BITS), .MAX_PKT(MAX_PKT)) u_alarm (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.write_ptr(write_ptr),
		.read_ptr(read_ptr),
		.inbound_store_strobe(inbound_store_strobe),
		.sorter_store_strobe(sorter_store_strobe),
		.merged_store_strobe(merged_store_strobe),
		.inbound_write_location(inbound_write_location),
		.sorter_write_location(sorter_write_location),
		.merged_write_location(merged_write_location),
		.fill_alarm(fill_alarm),
		.debug_out(debug_out)
	);

	// ========================================
	// readout pins: two-flop synchronisers and edge find
	logic rk_meta_reg, rk_sync_reg, rk_prev_reg, cf_meta_reg, cf_sync_reg;
	logic rk_rise;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rk_meta_reg <= 1'b0;
			rk_sync_reg <= 1'b0;
			rk_prev_reg <= 1'b0;
			cf_meta_reg <= 1'b0;
			cf_sync_reg <= 1'b0;
		end else begin
			rk_meta_reg <= readout_shift_clock;
			rk_sync_reg <= rk_meta_reg;
			rk_prev_reg <= rk_sync_reg;
			cf_meta_reg <= trigger_position_cfg;
			cf_sync_reg <= cf_meta_reg;
		end
	end

	assign rk_rise = rk_sync_reg & ~rk_prev_reg; // [RL7]

	// ========================================
	// register port and interrupts
	elc_ctrl_t ctrl_reg, ctrl_next;
	logic [ELC_EVT_W-1:0] irq_stat_reg, irq_stat_next, irq_en_reg, irq_en_next, evt;
	logic [31:0] rdata_reg, rdata_next;
	logic start_cmd, stop_cmd;
	elc_state_t state_reg, state_next;
	logic [CW-1:0] pos_reg, pos_next, fill_reg, fill_next;
	logic [EXT_AW-1:0] cfg_reg, cfg_next;

	always_comb begin
		ctrl_next = ctrl_reg;
		irq_en_next = irq_en_reg;
		irq_stat_next = irq_stat_reg;
		rdata_next = 32'h0000_0000;
		start_cmd = 1'b0;
		stop_cmd = 1'b0;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				ELC_ADDR_CTRL: begin
					ctrl_next = elc_ctrl_t'(reg_req.wdata[2:0]);
					start_cmd = reg_req.wdata[ELC_CTRL_START];
					stop_cmd = reg_req.wdata[ELC_CTRL_STOP];
				end
				ELC_ADDR_IRQ_EN: irq_en_next = reg_req.wdata[ELC_EVT_W-1:0];
				ELC_ADDR_IRQ_CLR: irq_stat_next = irq_stat_reg & ~reg_req.wdata[ELC_EVT_W-1:0];
				default: ;
			endcase
		end
		// a new event wins over a clear in the same cycle
		irq_stat_next = irq_stat_next | evt;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				ELC_ADDR_CTRL: rdata_next = {29'h0, ctrl_reg};
				ELC_ADDR_STATUS: begin
					rdata_next[0] = (state_reg == ST_CAPTURE) || (state_reg == ST_POST);
					rdata_next[1] = state_reg == ST_POST;
					rdata_next[2] = data_ready;
					rdata_next[3] = fill_alarm;
					rdata_next[ELC_STAT_FILL_LSB +: CW] = fill_reg;
				end
				ELC_ADDR_TRIGPOS: begin
					rdata_next[CW-1:0] = pos_reg;
					rdata_next[ELC_TPOS_CFG_LSB +: EXT_AW] = cfg_reg;
				end
				ELC_ADDR_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
				ELC_ADDR_IRQ_EN: rdata_next = {29'h0, irq_en_reg};
				ELC_ADDR_DEBUG: rdata_next = debug_out;
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_reg <= elc_ctrl_t'(ELC_CTRL_RST);
			irq_en_reg <= ELC_IRQ_RST;
			irq_stat_reg <= ELC_IRQ_RST;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ctrl_reg <= ctrl_next;
			irq_en_reg <= irq_en_next;
			irq_stat_reg <= irq_stat_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq = |(irq_stat_reg & irq_en_reg);

	// ========================================
	// capture and readout engine
	elc_ctrl_t run_reg, run_next;
	logic [EXT_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next, ext_addr_reg, ext_addr_next;
	logic [CW-1:0] post_reg, post_next, rd_cnt_reg, rd_cnt_next, word_reg, word_next, depth, wr_adv;
	logic [BW-1:0] bit_reg, bit_next;
	logic [PROBE_WIDTH-1:0] shift_reg, shift_next, ext_wdata_reg;
	logic ext_we_reg, ext_we_next, mem_we, trig_sel, trig_hit, fin;

	always_comb begin
		state_next = state_reg;
		run_next = run_reg;
		pos_next = pos_reg;
		fill_next = fill_reg;
		post_next = post_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		rd_cnt_next = rd_cnt_reg;
		word_next = word_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		cfg_next = cfg_reg;
		mem_we = 1'b0;
		trig_hit = 1'b0;
		fin = 1'b0;
		evt = '0;
		depth = run_reg.ext_store ? DEPTH_EXT : DEPTH_INT; // [RL5]
		trig_sel = run_reg.alarm_src ? fill_alarm : capture_trigger_in;
		wr_adv = ({1'b0, wr_ptr_reg} == CW'(depth - 1'b1)) ? '0 : CW'({1'b0, wr_ptr_reg} + 1'b1);
		if (rk_rise) begin
			cfg_next = {cfg_reg[EXT_AW-2:0], cf_sync_reg}; // [RL7] [RL8]
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (start_cmd) begin
					run_next = ctrl_next;
					// position kept inside the chosen buffer
					pos_next = ({1'b0, cfg_reg} >= (ctrl_next.ext_store ? DEPTH_EXT : DEPTH_INT)) ?
						CW'((ctrl_next.ext_store ? DEPTH_EXT : DEPTH_INT) - 1'b1) : {1'b0, cfg_reg}; // [RL3] [RL8]
					wr_ptr_next = '0;
					fill_next = '0;
					state_next = ST_CAPTURE;
				end
			end
			ST_CAPTURE, ST_POST: begin
				mem_we = 1'b1; // [RL1]
				wr_ptr_next = wr_adv[EXT_AW-1:0];
				fill_next = (fill_reg == depth) ? fill_reg : CW'(fill_reg + 1'b1);
				if (stop_cmd) begin
					fin = 1'b1;
				end else if (state_reg == ST_POST) begin
					post_next = CW'(post_reg - 1'b1);
					fin = post_reg == CW'(1);
				end else if (!run_reg.continuous && trig_sel && fill_reg >= pos_reg) begin // [RL2] [RL9]
					trig_hit = 1'b1;
					evt[ELC_EVT_TRIG] = 1'b1;
					post_next = CW'(depth - pos_reg - 1'b1); // [RL4]
					fin = post_next == '0;
					state_next = ST_POST;
				end
			end
			ST_DONE: begin
				word_next = '0;
				state_next = ST_LOAD;
			end
			ST_LOAD: state_next = ST_WAIT;
			ST_WAIT: state_next = ST_FETCH;
			ST_FETCH: begin
				shift_next = run_reg.ext_store ? ext_sram_rdata : int_rdata_reg;
				bit_next = '0;
				state_next = ST_SHIFT;
			end
			ST_SHIFT: begin
				if (rk_rise) begin
					shift_next = {1'b0, shift_reg[PROBE_WIDTH-1:1]}; // [RL6] [RL7]
					bit_next = BW'(bit_reg + 1'b1);
					if (bit_reg == BW'(PROBE_WIDTH - 1)) begin
						word_next = CW'(word_reg + 1'b1);
						rd_ptr_next = ({1'b0, rd_ptr_reg} == CW'(depth - 1'b1)) ? '0 : EXT_AW'(rd_ptr_reg + 1'b1);
						if (word_next == rd_cnt_reg) begin
							evt[ELC_EVT_RDONE] = 1'b1;
							state_next = ST_IDLE;
						end else begin
							state_next = ST_LOAD;
						end
					end
				end
			end
		endcase
		if (fin) begin
			// oldest sample sits at the next write slot once the buffer has wrapped
			rd_cnt_next = fill_next;
			rd_ptr_next = (fill_next == depth) ? wr_ptr_next : '0;
			evt[ELC_EVT_DONE] = 1'b1;
			state_next = ST_DONE; // [RL12]
		end
		ext_we_next = mem_we & run_reg.ext_store;
		ext_addr_next = mem_we ? wr_ptr_reg : rd_ptr_reg;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			run_reg <= elc_ctrl_t'(ELC_CTRL_RST);
			pos_reg <= '0;
			fill_reg <= '0;
			post_reg <= '0;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			rd_cnt_reg <= '0;
			word_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			cfg_reg <= '0;
			ext_we_reg <= 1'b0;
			ext_addr_reg <= '0;
			ext_wdata_reg <= '0;
		end else begin
			state_reg <= state_next;
			run_reg <= run_next;
			pos_reg <= pos_next;
			fill_reg <= fill_next;
			post_reg <= post_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			rd_cnt_reg <= rd_cnt_next;
			word_reg <= word_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			cfg_reg <= cfg_next;
			ext_we_reg <= ext_we_next;
			ext_addr_reg <= ext_addr_next;
			ext_wdata_reg <= probe_inputs;
		end
	end

	// internal store: written only while capturing, read into a register every cycle at the read pointer
	always_ff @(posedge core_clk) begin
		if (mem_we && !run_reg.ext_store) begin
			int_mem[wr_ptr_reg[INT_AW-1:0]] <= probe_inputs; // [RL1] [RL5]
		end
		int_rdata_reg <= int_mem[rd_ptr_reg[INT_AW-1:0]];
	end

	assign ext_sram_we = ext_we_reg;
	assign ext_sram_addr = ext_addr_reg;
	assign ext_sram_wdata = ext_wdata_reg;
	assign capture_serial_out = shift_reg[0];
	// held low in the done cycle, where the last external write is still in flight
	assign data_ready = (state_reg == ST_LOAD) || (state_reg == ST_WAIT)
		|| (state_reg == ST_FETCH) || (state_reg == ST_SHIFT); // [RL12]

	// ========================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_SAMPLE_EACH_EDGE: assert property ( // [RL1]
		(state_reg == ST_CAPTURE) |-> mem_we) else $error("capture cycle without a store write");
	AST_CONT_NO_TRIGGER: assert property ( // [RL2]
		run_reg.continuous && state_reg == ST_CAPTURE && !stop_cmd |=> state_reg == ST_CAPTURE)
		else $error("continuous capture left capture state");
	AST_POS_IN_RANGE: assert property ( // [RL3]
		state_reg == ST_CAPTURE |-> pos_reg < depth) else $error("trigger position beyond buffer");
	AST_PRE_HISTORY: assert property ( // [RL4]
		trig_hit |-> fill_reg >= pos_reg) else $error("trigger taken before pre-history filled");
	AST_POST_LEN: assert property ( // [RL4]
		trig_hit && !fin |=> CW'(post_reg + pos_reg + 1'b1) == depth) else $error("post count wrong");
	AST_CFG_COMMIT: assert property ( // [RL8]
		state_reg == ST_IDLE && start_cmd && {1'b0, cfg_reg} < DEPTH_INT |=> pos_reg == CW'($past(cfg_reg)))
		else $error("trigger position not taken from config");
	AST_TRIG_FLAG: assert property ( // [RL9]
		trig_hit |=> irq_stat_reg[ELC_EVT_TRIG] && state_reg inside {ST_POST, ST_DONE})
		else $error("trigger not recorded");
	AST_FROZEN: assert property ( // [RL12]
		data_ready |-> !mem_we && !ext_sram_we) else $error("store written while data ready");
	AST_SHIFT_OUT: assert property ( // [RL6] [RL7]
		state_reg == ST_SHIFT && rk_rise && bit_reg != BW'(PROBE_WIDTH - 1) |=> capture_serial_out == $past(shift_reg[1]))
		else $error("serial output did not advance");
	AST_READY_AFTER_LOAD: assert property ( // [RL6]
		state_reg == ST_DONE |=> state_reg == ST_LOAD ##1 state_reg == ST_WAIT
		##1 state_reg == ST_FETCH ##1 state_reg == ST_SHIFT)
		else $error("readout fetch sequence broken");

	COV_TRIGGERED: cover property (trig_hit ##[1:300] state_reg == ST_DONE);
	COV_CONT_STOP: cover property (run_reg.continuous && stop_cmd && state_reg == ST_CAPTURE);
	COV_READOUT_END: cover property (evt[ELC_EVT_RDONE]);
	COV_EXT_STORE: cover property (ext_sram_we);
endmodule
`default_nettype wire

//--- dv/elc_host_model.sv
// host model: drives the readout clock and the config line, collects serial samples
`default_nettype none
module elc_host_model #(
	parameter int W = 8
) (
	output logic readout_shift_clock,
	output logic trigger_position_cfg,
	input wire logic capture_serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [W-1:0] samp [0:31];
	initial begin
		readout_shift_clock = 1'b0;
		trigger_position_cfg = 1'b0;
	end
	// ========================================
	// config: msb first, one 160 ns clock per bit, clock still between frames
	task automatic send_cfg(input logic [11:0] v);
		for (int i = 11; i >= 0; i--) begin
			trigger_position_cfg = v[i];
			#80 readout_shift_clock = 1'b1;
			#80 readout_shift_clock = 1'b0;
		end
		// idle line shows the inverse of the last bit
		trigger_position_cfg = ~v[0];
	endtask
	// ========================================
	// readout: samples oldest first, lsb first, bit taken just before each rise
	task automatic read_samples(input int n);
		for (int s = 0; s < n; s++) begin
			for (int b = 0; b < W; b++) begin
				#70 samp[s][b] = capture_serial_out;
				#10 readout_shift_clock = 1'b1;
				#80 readout_shift_clock = 1'b0;
			end
		end
	endtask
endmodule
`default_nettype wire

//--- dv/elc_logging_core_tb.sv
// self-checking bench of the logging core: registers, debug word, captures and serial readout
`default_nettype none
module elc_logging_core_tb import elc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 8;
	localparam int IDEPTH = 16;
	localparam int EDEPTH = 32;
	typedef struct packed {logic [9:0] w; logic [9:0] r; logic a;} elc_row_t;
	elc_row_t rows [0:3] = '{'{10'h1F1, 10'h000, 1'b1}, '{10'h1F0, 10'h000, 1'b0},
		'{10'h258, 10'h064, 1'b1}, '{10'h254, 10'h064, 1'b0}};
	logic core_clk, rst_n, trig, we, ser_out, dr, irq, sclk, cfg;
	logic [PW-1:0] probe, sram_wd, sram_rd;
	logic [PW-1:0] sram [0:EDEPTH-1];
	logic [4:0] sram_a;
	logic [9:0] wp, rp;
	logic [2:0] stb;
	logic [8:0] loc [0:2];
	elc_reg_req_t req;
	logic [31:0] rdata, dbg, v;
	int fails, compares, cyc, we_rdy;

	elc_logging_core #(.PROBE_WIDTH(PW), .INT_AW(4), .EXT_AW(5)) i_elc_logging_core (
		.core_clk(core_clk), .rst_n(rst_n), .probe_inputs(probe), .capture_trigger_in(trig),
		.readout_shift_clock(sclk), .trigger_position_cfg(cfg), .capture_serial_out(ser_out),
		.data_ready(dr), .reg_req(req), .reg_rdata(rdata), .irq(irq), .ext_sram_addr(sram_a),
		.ext_sram_wdata(sram_wd), .ext_sram_we(we), .ext_sram_rdata(sram_rd), .write_ptr(wp),
		.read_ptr(rp), .inbound_store_strobe(stb[2]), .sorter_store_strobe(stb[1]),
		.merged_store_strobe(stb[0]), .inbound_write_location(loc[0]), .sorter_write_location(loc[1]),
		.merged_write_location(loc[2]), .debug_out(dbg));
	elc_host_model #(.W(PW)) i_elc_host_model (.readout_shift_clock(sclk), .trigger_position_cfg(cfg),
		.capture_serial_out(ser_out));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ========================================
	// probe counter, synchronous sram model, store watch and timeout
	always @(posedge core_clk) begin
		probe <= probe + 8'h01;
		cyc <= cyc + 1;
		if (dr === 1'b1 && we === 1'b1) we_rdy <= we_rdy + 1;
		if (we === 1'b1) sram[sram_a] <= sram_wd;
		sram_rd <= sram[sram_a];
		if (cyc == 20000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end
	// ========================================
	// tasks
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		req <= {1'b1, 1'b0, a, d};
		@(posedge core_clk);
		req <= '0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		req <= {1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk);
		req <= '0;
		#1 d = rdata;
	endtask
	task automatic wait_dr(input logic lvl);
		for (int i = 0; i < 400 && dr !== lvl; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk_word({31'h0, dr}, {31'h0, lvl});
	endtask
	task automatic run_cap(input logic [2:0] mode, input logic [11:0] pos, input int depth);
		int p;
		logic [PW-1:0] k, e;
		logic [31:0] r;
		p = (pos > depth - 1) ? depth - 1 : int'(pos);
		i_elc_host_model.send_cfg(pos);
		reg_wr(ELC_ADDR_CTRL, {29'h0, mode} | 32'h8);
		@(posedge core_clk);
		trig <= ~mode[2];
		@(posedge core_clk);
		trig <= 1'b0;
		if (mode[0]) begin
			repeat (60) @(posedge core_clk);
			#1 chk_word({31'h0, dr}, 32'h0);
			// stop lands on the edge after next, so the newest sample is probe plus one
			k = probe + 8'h02 - 8'(depth);
			reg_wr(ELC_ADDR_CTRL, {29'h0, mode} | 32'h10);
		end else begin
			repeat (20) @(posedge core_clk);
			trig <= ~mode[2];
			wp <= mode[2] ? 10'd600 : 10'd0;
			@(negedge core_clk);
			k = probe - 8'(p);
			@(posedge core_clk);
			trig <= 1'b0;
			wp <= 10'd0;
		end
		wait_dr(1'b1);
		reg_rd(ELC_ADDR_IRQ_STAT, r);
		chk_word(r, {30'h0, 1'b1, ~mode[0]});
		chk_word({31'h0, irq}, 32'h1);
		reg_wr(ELC_ADDR_IRQ_CLR, 32'h7);
		reg_rd(ELC_ADDR_STATUS, r);
		chk_word(r, (32'(depth) << 16) | 32'h4);
		chk_word({31'h0, irq}, 32'h0);
		reg_rd(ELC_ADDR_TRIGPOS, r);
		chk_word(r, (32'(pos[4:0]) << 16) | 32'(p));
		i_elc_host_model.read_samples(depth);
		for (int i = 0; i < depth; i++) begin
			e = k + 8'(i);
			chk_word({24'h0, i_elc_host_model.samp[i]}, {24'h0, e});
		end
		wait_dr(1'b0);
		reg_rd(ELC_ADDR_IRQ_STAT, r);
		chk_word(r, 32'h4);
		chk_word({31'h0, irq}, 32'h0);
		reg_wr(ELC_ADDR_IRQ_CLR, 32'h7);
		$display("capture mode %0h pos %0d done", mode, p);
	endtask
	task automatic report_and_stop();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ========================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		trig = 1'b0;
		req = '0;
		probe = 8'h00;
		wp = 10'h000;
		rp = 10'h000;
		stb = 3'h0;
		loc = '{9'h000, 9'h000, 9'h000};
		sram_rd = 8'h00;
		cyc = 0;
		fails = 0;
		compares = 0;
		we_rdy = 0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			reg_rd(8'(a * 4), v);
			chk_word(v, 32'h0);
		end
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			wp <= rows[i].w;
			rp <= rows[i].r;
			stb <= i[2:0] + 3'h1;
			loc <= '{9'h100 + i[8:0], 9'h0A0 + i[8:0], 9'h055 + i[8:0]};
			@(posedge core_clk);
			@(posedge core_clk);
			#1 chk_word(dbg, {rows[i].a, i[2:0] + 3'h1, 1'b0, 9'h100 + i[8:0], 9'h0A0 + i[8:0],
				9'h055 + i[8:0]});
		end
		wp <= 10'h000;
		rp <= 10'h000;
		$display("debug word done");
		reg_wr(ELC_ADDR_CTRL, 32'h7);
		reg_rd(ELC_ADDR_CTRL, v);
		chk_word(v, 32'h7);
		reg_wr(ELC_ADDR_CTRL, 32'h0);
		reg_wr(ELC_ADDR_IRQ_EN, 32'h2);
		run_cap(3'h0, 12'h005, IDEPTH);
		run_cap(3'h0, 12'h01F, IDEPTH);
		run_cap(3'h4, 12'h000, IDEPTH);
		run_cap(3'h3, 12'h000, EDEPTH);
		chk_word(32'(we_rdy), 32'h0);
		reg_wr(ELC_ADDR_CTRL, 32'h9);
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1 chk_word({30'h0, dr, irq}, 32'h0);
		reg_rd(ELC_ADDR_STATUS, v);
		chk_word(v, 32'h0);
		reg_rd(ELC_ADDR_CTRL, v);
		chk_word(v, 32'h0);
		$display("mid-run reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
